// file: core/bcc_map.svh
// Field positions, command codes and reset values of the branch coupler control
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// Control command codes
`define BCC_CMD_STATUS      8'h5a
`define BCC_CMD_ALLOFF      8'h66
`define BCC_CMD_DISCHARGE   8'h99

// Settings write byte fields
`define BCC_CB_DATA         7
`define BCC_CB_ASSOC        6
`define BCC_CB_MODE         5
`define BCC_CB_GUARD_HI     4
`define BCC_CB_GUARD_LO     3

// State report byte fields
`define BCC_IB_MAIN_STAT    0
`define BCC_IB_MAIN_LINE_LEVEL_SENSE    1
`define BCC_IB_AUX_STAT     2
`define BCC_IB_AUX_LINE_LEVEL_SENSE     3
`define BCC_IB_EVT_MAIN     4
`define BCC_IB_EVT_AUX      5
`define BCC_IB_CTL_REPORT   6
`define BCC_IB_MODE         7

// Power-on settings
`define BCC_RST_MODE        1'b0
`define BCC_RST_ASSOC       1'b0
`define BCC_RST_DATA        1'b0
`define BCC_RST_LEVEL       1'b1

// Bit counter
`define BCC_BIT_FIRST       3'h0
`define BCC_BIT_LAST        3'h7
`define BCC_BIT_STEP        3'h1

`endif

// file: core/bcc_pkg.sv
// Types shared by the branch coupler control modules
package bcc_pkg;

  typedef enum logic [2:0] {
    BCC_IDLE,
    BCC_CMD,
    BCC_CTRL,
    BCC_INFO,
    BCC_CONF,
    BCC_ECHO,
    BCC_DONE
  } bcc_phase_t;

  typedef struct packed {
    logic mainOn;
    logic auxOn;
    logic dischargeOn;
  } bcc_branch_t;

  typedef struct packed {
    bcc_phase_t phase;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] snap;
    logic       mode;
    logic       assoc;
    logic       ctlData;
    logic       mainOn;
    logic       auxOn;
    logic       discharge;
    logic       evMain;
    logic       evAux;
  } bcc_state_t;

  typedef struct packed {
    logic prevLevel;
  } bcc_edge_t;

endpackage

// file: core/bcc_edge_detect.sv
// Falling edge detector for one branch line while the branch is inactive
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"

module bcc_edge_detect
  import bcc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic lineLevel,
  input  wire logic lineIdle,
  output logic      fallEvt
);

  bcc_edge_t q;
  bcc_edge_t d;

  always_comb
  begin
    d = q;
    d.prevLevel = lineLevel;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '{prevLevel: `BCC_RST_LEVEL};
    else
      q <= d;
  end

  // Only counted while decoupled; a live branch toggles on every slot
  assign fallEvt = q.prevLevel & ~lineLevel & lineIdle;

  a_fall_detect: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (lineIdle && !lineLevel && $past(lineLevel)) |-> fallEvt)
    else $error("falling edge on idle branch not flagged");

endmodule
`default_nettype wire

// file: core/bcc_control.sv
// Control command interpreter of the branch coupler: status exchange and branch switching
//
// How it works
// - Status command: control byte in, info out
// - Confirmation byte repeats the info byte
// - Power-on: auto mode, control follows main
// - Control bit 6 picks associated branch
// - Control bit 5 picks auto or manual
// - Manual mode: bit 7 drives transistor
// - Update only when bits 3,4 zero
// - Info byte shows settings after update
// - Info bits 0,2: branch inactive flags
// - Info bits 1,3: sensed branch levels
// - Falling edge on inactive branch sets flag
// - Only all-lines-off clears event flags
// - Info bit 7 mode, bit 6 control
// - All-lines-off drops branches, ends discharge
// - All-lines-off in auto turns transistor off
// - Power-on leaves both branches off
// - All-lines-off keeps mode and association
// - One branch on switches other off
// - Every known command returns a feedback byte; unknown codes get none
// - Command is code plus optional bytes
// - Bytes travel least significant bit first
// - Commands accepted only after ROM addressing
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"

module bcc_control
  import bcc_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rst_b,
  input  wire logic  romDone,
  input  wire logic  busReset,
  input  wire logic  slotStb,
  input  wire logic  slotBit,
  output logic       readActive,
  output logic       readBit,
  input  wire logic  onMainReq,
  input  wire logic  onAuxReq,
  input  wire logic  mainLevel,
  input  wire logic  auxLevel,
  output bcc_branch_t branchOut,
  input  wire logic  ctlPinI,
  output logic       ctlPinO,
  output logic       ctlPinOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic ctlDrive(input bcc_state_t s);
    if (s.mode)
      ctlDrive = s.ctlData;
    else
      ctlDrive = s.assoc ? s.auxOn : s.mainOn;
  endfunction

  function automatic logic [7:0] infoByte(input bcc_state_t s,
                                          input logic       mLvl,
                                          input logic       aLvl);
    logic [7:0] b;
    b = 8'h00;
    b[`BCC_IB_MAIN_STAT]  = ~s.mainOn;
    b[`BCC_IB_MAIN_LINE_LEVEL_SENSE]  = mLvl;
    b[`BCC_IB_AUX_STAT]   = ~s.auxOn;
    b[`BCC_IB_AUX_LINE_LEVEL_SENSE]   = aLvl;
    b[`BCC_IB_EVT_MAIN]   = s.evMain;
    b[`BCC_IB_EVT_AUX]    = s.evAux;
    b[`BCC_IB_CTL_REPORT] = s.mode ? s.ctlData : s.assoc;
    b[`BCC_IB_MODE]       = s.mode;
    infoByte = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Edge detectors

  bcc_state_t q;
  bcc_state_t d;
  logic       mainFall;
  logic       auxFall;

  bcc_edge_detect uMainEdge (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .lineLevel (mainLevel),
    .lineIdle  (~q.mainOn),
    .fallEvt   (mainFall)
  );

  bcc_edge_detect uAuxEdge (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .lineLevel (auxLevel),
    .lineIdle  (~q.auxOn),
    .fallEvt   (auxFall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  logic [7:0] byteIn;
  logic       lastBit;
  logic       allOff;

  always_comb
  begin
    d       = q;
    allOff  = 1'b0;
    byteIn  = {slotBit, q.sh[7:1]};
    lastBit = slotStb && (q.cnt == `BCC_BIT_LAST);
    if (slotStb)
      d.cnt = q.cnt + `BCC_BIT_STEP;

    case (q.phase)
      BCC_IDLE:
      begin
        d.cnt = `BCC_BIT_FIRST;
        if (romDone)
          d.phase = BCC_CMD;
      end
      BCC_CMD:
      begin
        if (slotStb)
          d.sh = byteIn;
        if (lastBit)
        begin
          // Any new code ends a discharge
          d.discharge = 1'b0;
          if (byteIn == `BCC_CMD_STATUS)
            d.phase = BCC_CTRL;
          else if (byteIn == `BCC_CMD_ALLOFF)
          begin
            allOff  = 1'b1;
            d.phase = BCC_ECHO;
          end
          else if (byteIn == `BCC_CMD_DISCHARGE)
          begin
            d.mainOn    = 1'b0;
            d.auxOn     = 1'b0;
            d.discharge = 1'b1;
            d.phase     = BCC_ECHO;
          end
          else
            d.phase = BCC_DONE;
        end
      end
      BCC_CTRL:
      begin
        if (slotStb)
          d.sh = byteIn;
        if (lastBit)
        begin
          // Bits 0 to 2 are not looked at
          if (!byteIn[`BCC_CB_GUARD_HI] && !byteIn[`BCC_CB_GUARD_LO])
          begin
            d.mode    = byteIn[`BCC_CB_MODE];
            d.assoc   = byteIn[`BCC_CB_ASSOC];
            d.ctlData = byteIn[`BCC_CB_DATA];
          end
          d.phase = BCC_INFO;
        end
      end
      BCC_INFO, BCC_CONF, BCC_ECHO:
      begin
        if (slotStb)
          d.sh = {1'b0, q.sh[7:1]};
        if (lastBit)
        begin
          if (q.phase == BCC_INFO)
          begin
            d.sh    = q.snap;
            d.phase = BCC_CONF;
          end
          else
            d.phase = BCC_DONE;
        end
      end
      BCC_DONE:
      begin
        d.cnt = `BCC_BIT_FIRST;
      end
      default:
      begin
        d.phase = BCC_IDLE;
      end
    endcase

    if (allOff)
    begin
      // Mode, association and manual data stay as they are
      d.mainOn    = 1'b0;
      d.auxOn     = 1'b0;
      d.discharge = 1'b0;
      d.evMain    = 1'b0;
      d.evAux     = 1'b0;
    end

    if (onMainReq)
    begin
      d.mainOn = 1'b1;
      d.auxOn  = 1'b0;
    end
    else if (onAuxReq)
    begin
      d.auxOn  = 1'b1;
      d.mainOn = 1'b0;
    end

    // Set after the clear so an edge in the clearing cycle survives
    if (mainFall)
      d.evMain = 1'b1;
    if (auxFall)
      d.evAux = 1'b1;

    // Report built from the updated copy, flags of this cycle included
    if (q.phase == BCC_CTRL && lastBit)
    begin
      d.sh   = infoByte(d, mainLevel, auxLevel);
      d.snap = d.sh;
    end

    if (busReset)
    begin
      d.phase = BCC_IDLE;
      d.cnt   = `BCC_BIT_FIRST;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q           <= '0;
      q.phase     <= BCC_IDLE;
      q.mode      <= `BCC_RST_MODE;
      q.assoc     <= `BCC_RST_ASSOC;
      q.ctlData   <= `BCC_RST_DATA;
      q.mainOn    <= 1'b0;
      q.auxOn     <= 1'b0;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Read slots answer only while a byte is on its way to the master
  assign readActive = (q.phase == BCC_INFO) || (q.phase == BCC_CONF) || (q.phase == BCC_ECHO);
  assign readBit    = q.sh[0];

  assign branchOut.mainOn      = q.mainOn;
  assign branchOut.auxOn       = q.auxOn;
  assign branchOut.dischargeOn = q.discharge;

  // Open drain: only ever pulls low, pin level sensed outside
  assign ctlPinO  = 1'b0;
  assign ctlPinOe = ctlDrive(q);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_branch_exclusive: assert property (!(q.mainOn && q.auxOn))
    else $error("both branches on");

  a_auto_follow: assert property ((!q.mode && q.assoc) |-> (ctlPinOe == q.auxOn))
    else $error("control output not following aux branch");

  a_alloff_exec: assert property ((q.phase == BCC_CMD && lastBit && byteIn == `BCC_CMD_ALLOFF
      && !onMainReq && !onAuxReq && !busReset) |=> (!q.mainOn && !q.auxOn && !q.discharge
      && (q.mode || !ctlPinOe) && q.phase == BCC_ECHO))
    else $error("all-lines-off left a branch, discharge or transistor on");

  a_alloff_keep: assert property ((q.phase == BCC_CMD && lastBit && byteIn == `BCC_CMD_ALLOFF)
      |=> ($stable(q.mode) && $stable(q.assoc)))
    else $error("all-lines-off changed mode or association");

  a_guard_hold: assert property ((q.phase == BCC_CTRL && lastBit
      && (byteIn[`BCC_CB_GUARD_HI] || byteIn[`BCC_CB_GUARD_LO]))
      |=> ($stable(q.mode) && $stable(q.assoc) && $stable(q.ctlData)))
    else $error("guarded control byte changed settings");

  a_info_report: assert property ((q.phase == BCC_INFO && $past(q.phase) == BCC_CTRL)
      |-> (q.sh[`BCC_IB_MODE] == q.mode && q.sh[`BCC_IB_MAIN_STAT] == !q.mainOn
      && q.sh[`BCC_IB_CTL_REPORT] == (q.mode ? q.ctlData : q.assoc)))
    else $error("info byte does not match settings");

  a_conf_equal: assert property ((q.phase == BCC_CONF && $past(q.phase) == BCC_INFO)
      |-> (q.sh == q.snap && q.cnt == `BCC_BIT_FIRST))
    else $error("confirmation byte differs from info byte");

  a_flag_sticky: assert property ((q.evMain && !(q.phase == BCC_CMD && lastBit
      && byteIn == `BCC_CMD_ALLOFF)) |=> q.evMain)
    else $error("main event flag lost without all-lines-off");

  a_flag_set: assert property (auxFall |=> q.evAux)
    else $error("aux event flag not set");

  a_need_rom: assert property ((q.phase == BCC_IDLE && !romDone) |=> q.phase == BCC_IDLE)
    else $error("command phase entered without addressing");

  a_feedback: assert property ((q.phase == BCC_CTRL && lastBit && !busReset)
      |=> (readActive && q.phase == BCC_INFO))
    else $error("no feedback after control byte");

endmodule
`default_nettype wire

// file: tb/bcc_master_model.sv
// Bus master model: addressing, write slots and read slots
`timescale 1ns/10ps
`default_nettype none

module bcc_master_model
(
  input  wire logic sys_clk,
  input  wire logic readBit,
  output logic      romDone,
  output logic      busReset,
  output logic      slotStb,
  output logic      slotBit
);
  initial
  begin
    romDone  = 1'b0;
    busReset = 1'b0;
    slotStb  = 1'b0;
    slotBit  = 1'b0;
  end

  // Bus reset, then addressing done unless told to skip it
  task automatic start(input logic addr);
    @(posedge sys_clk);
    busReset <= 1'b1;
    @(posedge sys_clk);
    busReset <= 1'b0;
    romDone  <= addr;
    @(posedge sys_clk);
    romDone  <= 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      slotStb <= 1'b1;
      slotBit <= b[i];
    end
    @(posedge sys_clk);
    slotStb <= 1'b0;
    // Released line: show the inverse, not the last bit
    slotBit <= ~b[7];
  endtask

  // One idle cycle per slot so the registered answer bit has settled
  task automatic rd_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge sys_clk);
      b[i] = readBit;
      @(posedge sys_clk);
      slotStb <= 1'b1;
      slotBit <= 1'b1;
      @(posedge sys_clk);
      slotStb <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// file: tb/test_branch_coupler_control.sv
// Self-checking bench of the branch coupler control
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.svh"

`define TB_CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("MISMATCH %s exp %h got %h", nm, exp, got); \
    end \
  end

module test_branch_coupler_control
  import bcc_pkg::*;
;
  logic        sys_clk   = 1'b0;
  logic        rst_b     = 1'b0;
  logic        onMainReq = 1'b0;
  logic        onAuxReq  = 1'b0;
  logic        mainLevel = 1'b1;
  logic        auxLevel  = 1'b1;
  logic        romDone;
  logic        busReset;
  logic        slotStb;
  logic        slotBit;
  logic        readActive;
  logic        readBit;
  logic        ctlPinO;
  logic        ctlPinOe;
  wire logic   ctlPinI;
  bcc_branch_t branchOut;
  int          checked    = 0;
  int          mismatches = 0;
  logic [7:0]  info;
  logic [7:0]  echo;

  // Pull-up on the open-drain pin
  assign ctlPinI = ~ctlPinOe;

  always #2.5 sys_clk = ~sys_clk;

  bcc_master_model i_mst
  (
    .sys_clk  (sys_clk),
    .readBit  (readBit),
    .romDone  (romDone),
    .busReset (busReset),
    .slotStb  (slotStb),
    .slotBit  (slotBit)
  );

  bcc_control i_dut
  (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .romDone    (romDone),
    .busReset   (busReset),
    .slotStb    (slotStb),
    .slotBit    (slotBit),
    .readActive (readActive),
    .readBit    (readBit),
    .onMainReq  (onMainReq),
    .onAuxReq   (onAuxReq),
    .mainLevel  (mainLevel),
    .auxLevel   (auxLevel),
    .branchOut  (branchOut),
    .ctlPinI    (ctlPinI),
    .ctlPinO    (ctlPinO),
    .ctlPinOe   (ctlPinOe)
  );

  ////////////////////////////////////////////////////////////////////////////////

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Mask forces bits whose level is meaningless while coupled
  task automatic status(input logic [7:0] ctrl, input logic [7:0] expInfo,
                        input logic [7:0] mask);
    logic [7:0] conf;
    i_mst.start(1'b1);
    i_mst.wr_byte(`BCC_CMD_STATUS);
    i_mst.wr_byte(ctrl);
    @(negedge sys_clk);
    `TB_CHK("readActive", 1'b1, readActive)
    i_mst.rd_byte(info);
    i_mst.rd_byte(conf);
    `TB_CHK("info", expInfo, info | mask)
    `TB_CHK("confirm", info, conf)
    @(negedge sys_clk);
    `TB_CHK("readDone", 1'b0, readActive)
  endtask

  task automatic all_off();
    i_mst.start(1'b1);
    i_mst.wr_byte(`BCC_CMD_ALLOFF);
    i_mst.rd_byte(echo);
    `TB_CHK("echo", `BCC_CMD_ALLOFF, echo)
  endtask

  task automatic req(input logic m);
    @(posedge sys_clk);
    onMainReq <= m;
    onAuxReq  <= ~m;
    @(posedge sys_clk);
    onMainReq <= 1'b0;
    onAuxReq  <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic glitch(input logic aux);
    @(posedge sys_clk);
    if (aux)
      auxLevel <= 1'b0;
    else
      mainLevel <= 1'b0;
    @(posedge sys_clk);
    auxLevel  <= 1'b1;
    mainLevel <= 1'b1;
    @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    `TB_CHK("branches", 3'h0, branchOut)
    `TB_CHK("ctlOe", 1'b0, ctlPinOe)
    `TB_CHK("ctlPinO", 1'b0, ctlPinO)
    glitch(1'b0);
    status(8'hf8, 8'h1f, 8'h00);
    status(8'h47, 8'h5f, 8'h00);
    req(1'b0);
    `TB_CHK("auxOn", 3'h2, branchOut)
    `TB_CHK("ctlAux", 1'b1, ctlPinOe)
    req(1'b1);
    `TB_CHK("mainOn", 3'h4, branchOut)
    `TB_CHK("ctlMain", 1'b0, ctlPinOe)
    glitch(1'b1);
    status(8'h10, 8'h7e, 8'h02);
    req(1'b0);
    all_off();
    `TB_CHK("alloff", 3'h0, branchOut)
    `TB_CHK("ctlOff", 1'b0, ctlPinOe)
    status(8'h18, 8'h4f, 8'h00);
    status(8'ha0, 8'hcf, 8'h00);
    `TB_CHK("manualOn", 1'b1, ctlPinOe)
    // Both lines low while decoupled: level bits read 0, both flags set
    @(posedge sys_clk);
    mainLevel <= 1'b0;
    auxLevel  <= 1'b0;
    status(8'h18, 8'hf5, 8'h00);
    @(posedge sys_clk);
    mainLevel <= 1'b1;
    auxLevel  <= 1'b1;
    all_off();
    `TB_CHK("manualKept", 1'b1, ctlPinOe)
    status(8'h08, 8'hcf, 8'h00);
    status(8'h20, 8'h8f, 8'h00);
    `TB_CHK("manualOff", 1'b0, ctlPinOe)
    // Discharge holds both branches down until the next code
    i_mst.start(1'b1);
    i_mst.wr_byte(`BCC_CMD_DISCHARGE);
    i_mst.rd_byte(echo);
    `TB_CHK("dischEcho", `BCC_CMD_DISCHARGE, echo)
    `TB_CHK("discharge", 3'h1, branchOut)
    all_off();
    `TB_CHK("dischEnd", 3'h0, branchOut)
    // Slots without addressing, then an unknown code: both refused
    i_mst.start(1'b0);
    i_mst.wr_byte(`BCC_CMD_STATUS);
    @(negedge sys_clk);
    `TB_CHK("noAddr", 1'b0, readActive)
    i_mst.start(1'b1);
    i_mst.wr_byte(8'h12);
    @(negedge sys_clk);
    `TB_CHK("badCode", 1'b0, readActive)
    status(8'h00, 8'h0f, 8'h00);
    complete_run();
  end

  initial
  begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule

`default_nettype wire
